//--- slic_pkg.sv
/*
  shared constants and types of the serial control port of the line interface.
  assumes: the importing logic is clocked at 25 MHz; the host keeps its serial clock at 1 us or slower.
*/
package slic_pkg;

  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int WORD_WIDTH = 10;
  localparam int LINE_STATE_LSB = 0;
  localparam int LINE_STATE_WIDTH = 3;
  localparam int CURRENT_LIMIT_BIT = 6;
  localparam int TEST_LOAD_BIT = 8;
  localparam logic [9:0] CONTROL_RESET = 10'h000;
  localparam logic [4:0] CONTROL_FILL_HINT = 5'h1C;
  localparam int STATUS_FLAGS = 5;
  localparam logic [4:0] STATUS_PAD = 5'h1F;
  localparam int LOOP_LOW_BIT = 0;
  localparam int LOOP_HIGH_BIT = 1;
  localparam int RING_LOW_BIT = 2;
  localparam int RING_HIGH_BIT = 3;
  localparam int THERMAL_BIT = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_MIN_US = 1;
  localparam int LINK_PERIOD_MIN_CYC = (LINK_PERIOD_MIN_US * 1000) / CLK_PERIOD_NS;
  localparam int SYNC_LATENCY_CYC = 3;

  // ----------------------------------------
  // line state, code read as d0/d1/d2
  // ----------------------------------------
  typedef enum logic [2:0] {
    LINE_FORWARD,
    LINE_FORWARD_RAISED,
    LINE_REVERSE,
    LINE_WINK,
    LINE_TIP_OPEN,
    LINE_SCAN,
    LINE_RINGING,
    LINE_DISCONNECT
  } line_mode_e;

endpackage

//--- slic_link_capture.sv
/*
  serial clock side: samples the serial input on each rising clock edge and flags it with a toggle.
  assumes: the host clock may stop between frames; the reader synchronises the toggle before use.
*/
`timescale 1ns/1ps
module slic_link_capture
(
  // link
  input wire logic sclk,
  input wire logic din,
  // to system clock side
  output logic din_cap,
  output logic bit_toggle
);

  // --------------------------------
  // capture
  // --------------------------------
  // no reset here: shifting must go on while the device is held in reset
  logic din_cap_r = 1'b0;
  logic bit_toggle_r = 1'b0;

  always_ff @(posedge sclk)
  begin
    din_cap_r <= din;
    bit_toggle_r <= ~bit_toggle_r;
  end

  assign din_cap = din_cap_r;
  assign bit_toggle = bit_toggle_r;

endmodule // slic_link_capture

//--- slic_serial_control_port.sv
/*
  serial control and status port: 10-bit shift path, control latch, status load and line decode.
  assumes: host drives sclk, din and enable; status flags arrive as asynchronous levels from the analog side.
*/
`timescale 1ns/1ps
// Summary of operation
// - separate shift register and control latch
// - output repeats input ten clocks later
// - steady enable never alters control latch
// - enable rise loads status, shows bit zero
// - status shifts out, then delayed input resumes
// - input captured from second clock after rise
// - enable fall copies shift register to latch
// - only enable fall updates control word
// - reset forces control latch to zero
// - enable edges ignored while in reset
// - reset keeps shift register contents
// - in reset shift only while enable low
// - control field positions; spare bits don't-care
// - status word flags plus five ones
// - line state code decode
// - current limit bit low or high
// - test load bit switches test load
// - thermal bit zero during thermal shutdown
// - loop closure flag zero above threshold
// - ring trip flag zero above threshold
module slic_serial_control_port
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  input wire logic sclk,
  input wire logic din,
  input wire logic enable,
  output logic dout,
  // analog detector levels, high while current or temperature is over threshold
  input wire logic loop_over_low,
  input wire logic loop_over_high,
  input wire logic ring_over_low,
  input wire logic ring_over_high,
  input wire logic thermal_shutdown,
  // line settings
  output logic [slic_pkg::WORD_WIDTH-1:0] line_control_word,
  output slic_pkg::line_mode_e line_state_field,
  output logic current_limit_select,
  output logic test_load_switch_on
);
  import slic_pkg::*;

  // --------------------------------
  // checks
  // --------------------------------
  // the bit toggle must be seen before the next host clock edge
  if (LINK_PERIOD_MIN_CYC <= SYNC_LATENCY_CYC + 1)
  begin : g_bad_rate
    $error("system clock too slow for the serial link");
  end

  // --------------------------------
  // link capture and crossing
  // --------------------------------
  logic din_cap;
  logic bit_toggle;

  slic_link_capture u_link
  (
    .sclk(sclk),
    .din(din),
    .din_cap(din_cap),
    .bit_toggle(bit_toggle)
  );

  // these run through reset, so they carry initial values instead of a reset
  logic tog_m_r = 1'b0;
  logic tog_s_r = 1'b0;
  logic tog_d_r = 1'b0;
  logic en_m_r = 1'b0;
  logic en_s_r = 1'b0;
  logic en_d_r = 1'b0;
  logic shift_ev;
  logic en_rise;
  logic en_fall;

  always_ff @(posedge clk)
  begin
    tog_m_r <= bit_toggle;
    tog_s_r <= tog_m_r;
    tog_d_r <= tog_s_r;
    en_m_r <= enable;
    en_s_r <= en_m_r;
    en_d_r <= en_s_r;
  end

  // an enable edge made inside reset may still sit in the synchroniser when reset ends;
  // edges count only once the pipeline holds samples taken after release
  logic [1:0] settle_r;
  logic armed;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settle_r <= 2'h0;
    end
    else if (settle_r != 2'(SYNC_LATENCY_CYC))
    begin
      settle_r <= settle_r + 2'h1;
    end
  end

  assign armed = (settle_r == 2'(SYNC_LATENCY_CYC));

  // din_cap is steady for a whole host period after its toggle, so one sample here is safe
  assign shift_ev = tog_s_r ^ tog_d_r;
  assign en_rise = en_s_r & ~en_d_r & armed;
  assign en_fall = ~en_s_r & en_d_r & armed;

  // --------------------------------
  // status flags
  // --------------------------------
  logic [STATUS_FLAGS-1:0] flag_raw;
  logic [STATUS_FLAGS-1:0] flag_m_r;
  logic [STATUS_FLAGS-1:0] flag_s_r;
  logic [WORD_WIDTH-1:0] status_word;

  assign flag_raw[LOOP_LOW_BIT] = loop_over_low;
  assign flag_raw[LOOP_HIGH_BIT] = loop_over_high;
  assign flag_raw[RING_LOW_BIT] = ring_over_low;
  assign flag_raw[RING_HIGH_BIT] = ring_over_high;
  assign flag_raw[THERMAL_BIT] = thermal_shutdown;

  for (genvar i = 0; i < STATUS_FLAGS; i++)
  begin : g_flag_sync
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        flag_m_r[i] <= 1'b0;
        flag_s_r[i] <= 1'b0;
      end
      else
      begin
        flag_m_r[i] <= flag_raw[i];
        flag_s_r[i] <= flag_m_r[i];
      end
    end
  end

  // flags read zero while their condition holds
  assign status_word = {STATUS_PAD, ~flag_s_r};

  // --------------------------------
  // shift register
  // --------------------------------
  // no reset: asserting reset must leave the contents alone
  logic [WORD_WIDTH-1:0] shift_r = '0;
  logic skip_r = 1'b0;
  logic load;
  logic shift_ok;

  assign load = en_rise & rst_b;
  // in reset, a high enable freezes the register
  assign shift_ok = shift_ev & (rst_b | ~en_s_r);

  always_ff @(posedge clk)
  begin
    if (load)
    begin
      shift_r <= status_word;
    end
    else if (shift_ok && !skip_r)
    begin
      shift_r <= {din_cap, shift_r[WORD_WIDTH-1:1]};
    end
  end

  // the first host edge after a status load is passed over; the second takes new data
  always_ff @(posedge clk)
  begin
    if (load)
    begin
      skip_r <= 1'b1;
    end
    else if (shift_ok)
    begin
      skip_r <= 1'b0;
    end
  end

  assign dout = shift_r[0];

  // --------------------------------
  // control latch and decode
  // --------------------------------
  logic [WORD_WIDTH-1:0] ctrl_nxt;
  line_mode_e mode_nxt;
  logic [2:0] code;

  // a fall copies the word as it stands at that instant
  assign ctrl_nxt = en_fall ? shift_r : line_control_word;
  // the code is read d0/d1/d2, so d0 is the leading digit
  assign code = {ctrl_nxt[LINE_STATE_LSB], ctrl_nxt[LINE_STATE_LSB+1], ctrl_nxt[LINE_STATE_LSB+2]};

  always_comb
  begin
    mode_nxt = LINE_FORWARD;
    unique case (code)
      3'h0: mode_nxt = LINE_FORWARD;
      3'h1: mode_nxt = LINE_FORWARD_RAISED;
      3'h2: mode_nxt = LINE_REVERSE;
      3'h3: mode_nxt = LINE_WINK;
      3'h6: mode_nxt = LINE_TIP_OPEN;
      3'h4: mode_nxt = LINE_SCAN;
      3'h5: mode_nxt = LINE_RINGING;
      3'h7: mode_nxt = LINE_DISCONNECT;
    endcase
  end

  // only the latch drives the line; the shift register never does
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_control_word <= CONTROL_RESET;
      line_state_field <= LINE_FORWARD;
      current_limit_select <= 1'b0;
      test_load_switch_on <= 1'b0;
    end
    else
    begin
      line_control_word <= ctrl_nxt;
      line_state_field <= mode_nxt;
      current_limit_select <= ctrl_nxt[CURRENT_LIMIT_BIT];
      test_load_switch_on <= ctrl_nxt[TEST_LOAD_BIT];
    end
  end

  // --------------------------------
  // assertions
  // --------------------------------
  AST_LATCH_STEADY: assert property (@(posedge clk) disable iff (!rst_b)
    !en_fall |=> $stable(line_control_word))
    else $error("control latch changed without enable fall");

  AST_FALL_COPY: assert property (@(posedge clk) disable iff (!rst_b)
    en_fall |=> line_control_word == $past(shift_r))
    else $error("enable fall did not copy shift register");

  AST_RESET_ZERO: assert property (@(posedge clk)
    (!rst_b && $past(!rst_b)) |-> (line_control_word == CONTROL_RESET && !test_load_switch_on))
    else $error("control latch not zero in reset");

  AST_RISE_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    en_rise |=> (shift_r == $past(status_word)) && (dout == $past(status_word[0])))
    else $error("status not loaded on enable rise");

  AST_RESET_FREEZE: assert property (@(posedge clk)
    (!rst_b && en_s_r) |=> $stable(shift_r))
    else $error("shift register moved in reset with enable high");

  AST_SHIFT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    (shift_ev && !en_rise && !skip_r) |=> shift_r == {$past(din_cap), $past(shift_r[WORD_WIDTH-1:1])})
    else $error("shift step wrong");

  AST_SKIP_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
    (skip_r && shift_ev && !load) |=> ($stable(shift_r) && !skip_r))
    else $error("first edge after load shifted");

  AST_SKIP_SET: assert property (@(posedge clk) disable iff (!rst_b)
    load |=> skip_r)
    else $error("status load did not arm the skip");

  AST_RESET_SHIFT: assert property (@(posedge clk)
    (!rst_b && !en_s_r && shift_ev && !skip_r)
      |=> shift_r == {$past(din_cap), $past(shift_r[WORD_WIDTH-1:1])})
    else $error("shift register did not move in reset with enable low");

  AST_DECODE: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h1) |-> line_state_field == LINE_SCAN)
    else $error("line state decode wrong");

  AST_DECODE_FWD: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h0) |-> line_state_field == LINE_FORWARD)
    else $error("forward decode wrong");

  AST_DECODE_RAISED: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h4) |-> line_state_field == LINE_FORWARD_RAISED)
    else $error("raised common mode decode wrong");

  AST_DECODE_REV: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h2) |-> line_state_field == LINE_REVERSE)
    else $error("reverse decode wrong");

  AST_DECODE_WINK: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h6) |-> line_state_field == LINE_WINK)
    else $error("wink decode wrong");

  AST_DECODE_TIP: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h3) |-> line_state_field == LINE_TIP_OPEN)
    else $error("tip open decode wrong");

  AST_DECODE_RING: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h5) |-> line_state_field == LINE_RINGING)
    else $error("ringing decode wrong");

  AST_DECODE_DISC: assert property (@(posedge clk) disable iff (!rst_b)
    (line_control_word[2:0] == 3'h7) |-> line_state_field == LINE_DISCONNECT)
    else $error("disconnect decode wrong");

  AST_FIELDS: assert property (@(posedge clk) disable iff (!rst_b)
    current_limit_select == line_control_word[CURRENT_LIMIT_BIT]
      && test_load_switch_on == line_control_word[TEST_LOAD_BIT])
    else $error("field outputs disagree with latch");

  AST_THERMAL: assert property (@(posedge clk) disable iff (!rst_b)
    flag_s_r[THERMAL_BIT] |-> !status_word[THERMAL_BIT])
    else $error("thermal bit polarity wrong");

  AST_LOOP_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    status_word[LOOP_LOW_BIT] == !flag_s_r[LOOP_LOW_BIT])
    else $error("low loop closure bit polarity wrong");

  AST_LOOP_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    status_word[LOOP_HIGH_BIT] == !flag_s_r[LOOP_HIGH_BIT])
    else $error("high loop closure bit polarity wrong");

  AST_RING_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    status_word[RING_LOW_BIT] == !flag_s_r[RING_LOW_BIT])
    else $error("low ring trip bit polarity wrong");

  AST_RING_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    status_word[RING_HIGH_BIT] == !flag_s_r[RING_HIGH_BIT])
    else $error("high ring trip bit polarity wrong");

  AST_STATUS_PAD: assert property (@(posedge clk) disable iff (!rst_b)
    status_word[WORD_WIDTH-1:STATUS_FLAGS] == STATUS_PAD)
    else $error("status pad bits not ones");

  COV_LOAD: cover property (@(posedge clk) disable iff (!rst_b) en_rise);
  COV_UPDATE: cover property (@(posedge clk) disable iff (!rst_b) en_fall ##1 test_load_switch_on);
  COV_RESET_SHIFT: cover property (@(posedge clk) !rst_b && shift_ok);
  COV_RESET_FREEZE: cover property (@(posedge clk) !rst_b && en_s_r && shift_ev);
  COV_SKIP: cover property (@(posedge clk) disable iff (!rst_b) skip_r && shift_ev);

endmodule // slic_serial_control_port

//--- slic_host_model.sv
/*
  host model: drives serial clock, data and enable, and samples the serial output.
  assumes: the device shifts on rising serial clock edges and is driven by one host only.
*/
`timescale 1ns/1ps
module slic_host_model
(
  // serial link
  output logic sclk,
  output logic din,
  output logic enable,
  input wire logic dout
);
  initial
  begin
    sclk = 1'b0;
    din = 1'b0;
    enable = 1'b0;
  end

  // ----------------------------------------
  // one rising edge, 1 us period; clock stands still between frames
  // ----------------------------------------
  task automatic pulse();
    sclk = 1'b1;
    #32 sclk = 1'b0;
    #168 din = ~din; // hold over: show garbage, never the last bit
    #500;
  endtask

  task automatic set_en(input logic v);
    enable = v;
    #500;
  endtask

  // en=1: write frame with status read back; en=0: plain shift
  task automatic frame(input logic en, input logic [9:0] w, output logic [9:0] st);
    if (en)
    begin
      enable = 1'b1;
      #500 pulse(); // first edge after the rise carries no data
    end
    for (int k = 0; k < 10; k++)
    begin
      din = w[k];
      #300 st[k] = dout;
      pulse();
    end
    if (en)
      enable = 1'b0;
    #500;
  endtask
endmodule // slic_host_model

//--- slic_serial_control_port_tb.sv
/*
  testbench of the serial control port: host frames, detector levels and reset against expected words.
  assumes: host model in its own file; design assertions sit inside the design files.
*/
`timescale 1ns/1ps
module slic_serial_control_port_tb;
  import slic_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic sclk, din, enable, dout;
  logic [4:0] over = 5'h00;
  logic [9:0] line_control_word;
  line_mode_e line_state_field;
  logic current_limit_select, test_load_switch_on;
  logic [9:0] st, w;
  logic [2:0] lc;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  slic_serial_control_port dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .din(din), .enable(enable),
    .dout(dout), .loop_over_low(over[0]), .loop_over_high(over[1]), .ring_over_low(over[2]),
    .ring_over_high(over[3]), .thermal_shutdown(over[4]), .line_control_word(line_control_word),
    .line_state_field(line_state_field), .current_limit_select(current_limit_select),
    .test_load_switch_on(test_load_switch_on));
  slic_host_model host_u (.sclk(sclk), .din(din), .enable(enable), .dout(dout));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected line mode for a code read d0/d1/d2 as a number
  function automatic line_mode_e mode_of(input logic [2:0] c);
    line_mode_e m;
    m = LINE_FORWARD;
    case (c)
      3'h1: m = LINE_FORWARD_RAISED;
      3'h2: m = LINE_REVERSE;
      3'h3: m = LINE_WINK;
      3'h4: m = LINE_SCAN;
      3'h5: m = LINE_RINGING;
      3'h6: m = LINE_TIP_OPEN;
      3'h7: m = LINE_DISCONNECT;
      default: m = LINE_FORWARD;
    endcase
    return m;
  endfunction

  task automatic outs(input logic [9:0] lw, input line_mode_e ls, input logic cl, input logic tl);
    check(line_control_word, lw);
    check({7'h00, line_state_field}, {7'h00, ls});
    check({9'h000, current_limit_select}, {9'h000, cl});
    check({9'h000, test_load_switch_on}, {9'h000, tl});
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a hang costs a mismatch; whole run needs about 5300 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    // a real falling edge on reset, so the latch is cleared before the first clock
    #1 rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    outs(10'h000, LINE_FORWARD, 1'b0, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      @(negedge clk);
      lc = 3'(c);
      over = 5'(c * 5 + 3);
      // line code read d0/d1/d2, spare bits get the 11100 fill
      w = {1'b0, lc[1], 1'b0, lc[0], 3'b111, lc[0], lc[1], lc[2]};
      repeat (4) @(negedge clk);
      host_u.frame(1'b1, w, st);
      check(st, {5'h1F, ~over});
      outs(w, mode_of(lc), lc[0], lc[1]);
      host_u.frame(1'b0, ~w, st);
      check(st, w);
      outs(w, mode_of(lc), lc[0], lc[1]);
    end
    @(negedge clk);
    rst_b = 1'b0;
    #200;
    outs(10'h000, LINE_FORWARD, 1'b0, 1'b0);
    host_u.frame(1'b0, 10'h2B3, st);
    check(st, ~w);
    host_u.set_en(1'b1);
    host_u.frame(1'b0, 10'h0F0, st);
    check(st, 10'h3FF);
    host_u.set_en(1'b0);
    outs(10'h000, LINE_FORWARD, 1'b0, 1'b0);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    host_u.frame(1'b0, 10'h155, st);
    check(st, 10'h2B3);
    outs(10'h000, LINE_FORWARD, 1'b0, 1'b0);
    give_verdict();
  end
endmodule // slic_serial_control_port_tb
